// >>> src/cdalu_bcd_conv.sv
/*
  Combinational packed-BCD to binary and binary to packed-BCD converter.
  Assumes the caller registers the outputs; digits beyond DIGITS are dropped.
*/
`timescale 1ns/1ps
module cdalu_bcd_conv #(
  parameter int DIGITS = 8,
  parameter int BIN_W  = 32
) (
  input  wire logic [4*DIGITS-1:0] bcd_in,
  input  wire logic [BIN_W-1:0]    bin_in,
  output logic      [BIN_W-1:0]    bin_out,
  output logic      [4*DIGITS-1:0] bcd_out
);

  logic [BIN_W+4*DIGITS-1:0] sh;

  // Weighted sum, most significant digit first
  always_comb begin
    bin_out = '0;
    for (int d = DIGITS - 1; d >= 0; d--) begin
      bin_out = BIN_W'(bin_out * BIN_W'(10) + BIN_W'(bcd_in[4*d +: 4]));
    end
  end

  // Shift-and-add-three
  always_comb begin
    sh = '0;
    sh[BIN_W-1:0] = bin_in;
    for (int i = 0; i < BIN_W; i++) begin
      for (int d = 0; d < DIGITS; d++) begin
        if (sh[BIN_W+4*d +: 4] >= 4'h5) begin
          sh[BIN_W+4*d +: 4] = 4'(sh[BIN_W+4*d +: 4] + 4'h3);
        end
      end
      sh = sh << 1;
    end
    bcd_out = sh[BIN_W +: 4*DIGITS];
  end

endmodule

// >>> src/cdalu_defines.svh
/*
  Register map, field positions, reset values and time-unit constants of the
  controller data-conversion datapath.
  Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
*/
`ifndef CDALU_DEFINES_SVH
`define CDALU_DEFINES_SVH

// Byte offsets of the register words
`define CDALU_OFF_OPCODE     10'h000
`define CDALU_OFF_SRC1       10'h004
`define CDALU_OFF_SRC2       10'h008
`define CDALU_OFF_DST        10'h00C
`define CDALU_OFF_CTRL       10'h010
`define CDALU_OFF_STATUS     10'h014
`define CDALU_OFF_RESULT     10'h018
`define CDALU_OFF_RESULT_HI  10'h01C
// Operand memory window, one 16-bit word per bus word
`define CDALU_MEM_BASE_IDX   8'h80

// Control word fields
`define CDALU_CTRL_EXEC      0
`define CDALU_CTRL_DIR       1
`define CDALU_CTRL_ENTRY     2
`define CDALU_CTRL_SIZE_LO   4
`define CDALU_CTRL_SIZE_HI   5

// Status word fields
`define CDALU_STAT_CARRY     0
`define CDALU_STAT_GT        1
`define CDALU_STAT_EQ        2
`define CDALU_STAT_LT        3
`define CDALU_STAT_BUSY      4

// Reset values
`define CDALU_RST_WORD       32'h0000_0000
`define CDALU_RST_SIZE       2'h0

// Time-of-day conversion, counts of tenth-second units and of seconds
`define CDALU_TICKS_PER_SEC  32'd10
`define CDALU_TICKS_PER_MIN  32'd600
`define CDALU_TICKS_PER_HOUR 32'd36000
`define CDALU_SEC_PER_MIN    32'd60
`define CDALU_SEC_PER_HOUR   32'd3600

`endif

// >>> src/cdalu_pkg.sv
/*
  Types of the controller data-conversion datapath: operation codes, operand
  sizes and sequencer states.
  Assumes cdalu_defines.svh is included by the modules that need numbers.
*/
package cdalu_pkg;

  typedef enum logic [4:0] {
    parity_make_odd, parity_make_even, parity_check_odd, parity_check_even,
    decimal_to_binary, binary_to_decimal, char_to_binary, binary_to_char,
    one_hot_decode, priority_encode, segment_encode, time_to_ticks,
    ticks_to_time, code_table_set, code_table_out_raw, code_table_out_converted,
    compare_op, bit_set_op, bit_clear_op, bit_extract_op, ones_count,
    shift_right_one, shift_left_one, shift_right_count, shift_left_count,
    shift_dir_one, shift_dir_count
  } cdalu_op_t;

  typedef enum logic [1:0] {
    size_8, size_16, size_32
  } cdalu_size_t;

  typedef enum logic [1:0] {
    st_idle, st_exec, st_loop
  } cdalu_state_t;

endpackage

// >>> src/cdalu_top.sv
/*
  Data-conversion execution datapath of a controller CPU: parity, BCD and
  character conversions, decode/encode, seven-segment, time of day, code
  tables, compare, bit operations, ones count and shifts.
  Assumes a byte-addressed Avalon-MM master with waitrequest on one clock.
*/
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "cdalu_defines.svh"

module cdalu_top #(
  parameter int MEM_WORDS = 64
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             busy,
  output logic             carry_flag,
  output logic             greater_flag,
  output logic             equal_flag,
  output logic             less_flag
);
  import cdalu_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  typedef struct packed {
    cdalu_state_t               st;
    logic [4:0]                 op;
    logic [1:0]                 size;
    logic                       dir;
    logic                       entry;
    logic [31:0]                src1;
    logic [31:0]                src2;
    logic [31:0]                dst;
    logic [31:0]                result;
    logic [31:0]                result_hi;
    logic                       carry;
    logic                       gt;
    logic                       eq;
    logic                       lt;
    logic [7:0]                 idx;
    logic [31:0]                acc;
    logic                       wreq;
    logic                       run;
    logic [31:0]                rdata;
    logic [MEM_WORDS-1:0][15:0] mem;
  } cdalu_core_t;

  localparam cdalu_core_t CORE_RST = '{st: st_idle, size: `CDALU_RST_SIZE, wreq: 1'b1,
                                       default: '0};

  cdalu_core_t s_q, s_d;

  cdalu_op_t   opc;
  logic [31:0] mask;
  logic [4:0]  top;
  logic [31:0] x1;
  logic [31:0] x2;
  logic [4:0]  pos;
  logic [AW-1:0] a_src, a_src1, a_dst, a_dst1, a_tbl, a_set, a_ld;
  logic [15:0] tbl_entry;
  logic [31:0] bcd_in, dec_bin, bin_dec;
  logic [31:0] hex_val, acc_n, tk, secs;
  logic [7:0]  nib_sh;
  logic [7:0]  idx_n;
  logic [7:0]  mem_off;
  logic        mem_hit;

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    unique case (sz)
      2'h0:    size_mask = 32'h0000_00FF;
      2'h1:    size_mask = 32'h0000_FFFF;
      default: size_mask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] n);
    unique case (n)
      4'h0: seg7 = 7'h3F;  4'h1: seg7 = 7'h06;  4'h2: seg7 = 7'h5B;  4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;  4'h5: seg7 = 7'h6D;  4'h6: seg7 = 7'h7D;  4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;  4'h9: seg7 = 7'h6F;  4'hA: seg7 = 7'h77;  4'hB: seg7 = 7'h7C;
      4'hC: seg7 = 7'h39;  4'hD: seg7 = 7'h5E;  4'hE: seg7 = 7'h79;  4'hF: seg7 = 7'h71;
    endcase
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? 8'(8'h30 + 8'(n)) : 8'(8'h37 + 8'(n));
  endfunction

  // Non-hex characters count as zero
  function automatic logic [3:0] char_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      char_val = 4'(c - 8'h30);
    end else if (c >= 8'h41 && c <= 8'h46) begin
      char_val = 4'(c - 8'h37);
    end else if (c >= 8'h61 && c <= 8'h66) begin
      char_val = 4'(c - 8'h57);
    end else begin
      char_val = 4'h0;
    end
  endfunction

  function automatic logic [31:0] bcd_byte(input logic [7:0] b);
    bcd_byte = 32'(b[7:4]) * 32'd10 + 32'(b[3:0]);
  endfunction

  // Two BCD digits; hours above 99 wrap
  function automatic logic [7:0] two_digits(input logic [31:0] v);
    two_digits = {4'((v / 32'd10) % 32'd10), 4'(v % 32'd10)};
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    be_merge = old;
  endfunction

  cdalu_bcd_conv #(
    .DIGITS (8),
    .BIN_W  (32)
  ) u_conv (
    .bcd_in  (bcd_in),
    .bin_in  (x1),
    .bin_out (dec_bin),
    .bcd_out (bin_dec)
  );

  always_comb begin
    opc       = cdalu_op_t'(s_q.op);
    mask      = size_mask(s_q.size);
    top       = (s_q.size == 2'h0) ? 5'd7 : (s_q.size == 2'h1) ? 5'd15 : 5'd31;
    x1        = s_q.src1 & mask;
    x2        = s_q.src2 & mask;
    pos       = s_q.src1[4:0] & top;
    a_src     = AW'(s_q.src1 + 32'(s_q.idx));
    a_src1    = AW'(s_q.src1 + 32'd1);
    a_dst     = AW'(s_q.dst + 32'(s_q.idx));
    a_dst1    = AW'(s_q.dst + 32'd1);
    a_ld      = AW'(s_q.dst);
    a_tbl     = AW'(s_q.src2 + s_q.src1);
    a_set     = AW'(s_q.dst + s_q.src2);
    tbl_entry = s_q.mem[a_tbl];
    bcd_in    = (opc == code_table_out_converted) ? {16'h0000, tbl_entry} : x1;
    hex_val   = {s_q.mem[a_src1], s_q.mem[AW'(s_q.src1)]};
    idx_n     = 8'(s_q.idx + 8'd1);
    nib_sh    = 8'((s_q.src2[7:0] - idx_n) << 2);
    acc_n     = {s_q.acc[27:0], char_val(s_q.mem[a_src][7:0])};
    tk        = bcd_byte(s_q.mem[a_src1][7:0]) * `CDALU_TICKS_PER_HOUR
              + bcd_byte(s_q.mem[AW'(s_q.src1)][15:8]) * `CDALU_TICKS_PER_MIN
              + bcd_byte(s_q.mem[AW'(s_q.src1)][7:0]) * `CDALU_TICKS_PER_SEC;
    secs      = s_q.src1 / `CDALU_TICKS_PER_SEC;
    mem_off   = 8'(avs_address[9:2] - `CDALU_MEM_BASE_IDX);
    mem_hit   = mem_off < 8'(MEM_WORDS);

    s_d      = s_q;
    s_d.wreq = 1'b1;

    unique case (s_q.st)
      st_idle: begin
      end
      st_exec: begin
        s_d.st = st_idle;
        case (opc)
          parity_make_odd:   s_d.result = {24'h0, ~(^x1[6:0]), x1[6:0]};
          parity_make_even:  s_d.result = {24'h0, ^x1[6:0], x1[6:0]};
          parity_check_odd:  s_d.carry = ~(^x1);
          parity_check_even: s_d.carry = ^x1;
          decimal_to_binary: s_d.result = dec_bin & mask;
          binary_to_decimal: s_d.result = bin_dec & mask;
          one_hot_decode:    s_d.result = 32'h0000_0001 << s_q.src1[3:0];
          priority_encode: begin
            s_d.result = s_q.dst & 32'hFFFF_FFF0;
            for (int i = 15; i >= 0; i--) begin
              if (s_q.src1[i]) begin
                s_d.result = (s_q.dst & 32'hFFFF_FFF0) | 32'(i);
              end
            end
          end
          time_to_ticks: begin
            s_d.result    = tk;
            s_d.mem[a_ld] = tk[15:0];
            s_d.mem[a_dst1] = tk[31:16];
          end
          ticks_to_time: begin
            s_d.mem[a_ld]   = {two_digits((secs / `CDALU_SEC_PER_MIN) % 32'd60),
                               two_digits(secs % `CDALU_SEC_PER_MIN)};
            s_d.mem[a_dst1] = {8'h00, two_digits(secs / `CDALU_SEC_PER_HOUR)};
          end
          code_table_set: s_d.mem[a_set] = s_q.src1[15:0];
          code_table_out_raw: begin
            s_d.result    = {16'h0000, tbl_entry};
            s_d.mem[a_ld] = tbl_entry;
          end
          code_table_out_converted: begin
            s_d.mem[a_dst1]  = tbl_entry;
            s_d.mem[a_ld]    = dec_bin[15:0];
            s_d.result       = dec_bin;
            s_d.result_hi    = {16'h0000, tbl_entry};
          end
          compare_op: begin
            s_d.gt = x1 > x2;
            s_d.eq = x1 == x2;
            s_d.lt = x1 < x2;
          end
          bit_set_op:     s_d.result = (s_q.dst | (32'h1 << pos)) & mask;
          bit_clear_op:   s_d.result = (s_q.dst & ~(32'h1 << pos)) & mask;
          bit_extract_op: s_d.carry = x2[pos];
          ones_count:     s_d.result = 32'($countones(x1));
          shift_right_one: begin
            s_d.result = (x1 >> 1) | (32'(s_q.entry) << top);
            s_d.carry  = x1[0];
          end
          shift_left_one: begin
            s_d.result = ((x1 << 1) | 32'(s_q.entry)) & mask;
            s_d.carry  = x1[top];
          end
          shift_right_count: s_d.result = x1 >> s_q.src2[5:0];
          shift_left_count:  s_d.result = (x1 << s_q.src2[5:0]) & mask;
          shift_dir_one: begin
            s_d.result = s_q.dir ? (x1 << 1) & mask : x1 >> 1;
          end
          shift_dir_count: begin
            s_d.result = s_q.dir ? (x1 << s_q.src2[5:0]) & mask
                                 : x1 >> s_q.src2[5:0];
          end
          char_to_binary, binary_to_char, segment_encode: begin
            // Counted operations walk one element per cycle
            s_d.idx = 8'h00;
            s_d.acc = 32'h0000_0000;
            s_d.st  = (s_q.src2[7:0] == 8'h00) ? st_idle : st_loop;
          end
          default: begin
          end
        endcase
      end
      st_loop: begin
        s_d.idx = idx_n;
        case (opc)
          char_to_binary: begin
            s_d.acc = acc_n;
            if (idx_n == s_q.src2[7:0]) begin
              s_d.result      = acc_n;
              s_d.mem[a_ld]   = acc_n[15:0];
              s_d.mem[a_dst1] = acc_n[31:16];
            end
          end
          binary_to_char: s_d.mem[a_dst] = {8'h00, hex_char(4'(hex_val >> nib_sh))};
          segment_encode: s_d.mem[a_dst] = {9'h000, seg7(s_q.mem[a_src][3:0])};
          default: begin
          end
        endcase
        if (idx_n == s_q.src2[7:0]) begin
          s_d.st = st_idle;
        end
      end
      default: s_d.st = st_idle;
    endcase

    // Reads are served in any state; writes wait so operands stay stable
    if (s_q.wreq && avs_read) begin
      s_d.wreq  = 1'b0;
      s_d.rdata = `CDALU_RST_WORD;
      if (mem_hit) begin
        s_d.rdata = {16'h0000, s_q.mem[AW'(mem_off)]};
      end else begin
        case (avs_address)
          `CDALU_OFF_OPCODE:    s_d.rdata = {27'h0, s_q.op};
          `CDALU_OFF_SRC1:      s_d.rdata = s_q.src1;
          `CDALU_OFF_SRC2:      s_d.rdata = s_q.src2;
          `CDALU_OFF_DST:       s_d.rdata = s_q.dst;
          `CDALU_OFF_CTRL:      s_d.rdata = {26'h0, s_q.size, 1'b0, s_q.entry, s_q.dir, 1'b0};
          `CDALU_OFF_STATUS:    s_d.rdata = {27'h0, s_q.st != st_idle, s_q.lt, s_q.eq,
                                             s_q.gt, s_q.carry};
          `CDALU_OFF_RESULT:    s_d.rdata = s_q.result;
          `CDALU_OFF_RESULT_HI: s_d.rdata = s_q.result_hi;
          default:              s_d.rdata = `CDALU_RST_WORD;
        endcase
      end
    end else if (s_q.wreq && avs_write && s_q.st == st_idle) begin
      s_d.wreq = 1'b0;
      if (mem_hit) begin
        s_d.mem[AW'(mem_off)] = 16'(be_merge({16'h0000, s_q.mem[AW'(mem_off)]},
                                             avs_writedata, avs_byteenable));
      end else begin
        case (avs_address)
          `CDALU_OFF_OPCODE: s_d.op = 5'(be_merge({27'h0, s_q.op}, avs_writedata,
                                                  avs_byteenable));
          `CDALU_OFF_SRC1:   s_d.src1 = be_merge(s_q.src1, avs_writedata, avs_byteenable);
          `CDALU_OFF_SRC2:   s_d.src2 = be_merge(s_q.src2, avs_writedata, avs_byteenable);
          `CDALU_OFF_DST:    s_d.dst = be_merge(s_q.dst, avs_writedata, avs_byteenable);
          `CDALU_OFF_CTRL: begin
            if (avs_byteenable[0]) begin
              s_d.dir   = avs_writedata[`CDALU_CTRL_DIR];
              s_d.entry = avs_writedata[`CDALU_CTRL_ENTRY];
              s_d.size  = avs_writedata[`CDALU_CTRL_SIZE_HI:`CDALU_CTRL_SIZE_LO];
              if (avs_writedata[`CDALU_CTRL_EXEC]) begin
                s_d.st = st_exec;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Busy comes from its own flop, so the pin carries no state decode
    s_d.run = s_d.st != st_idle;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
  assign busy            = s_q.run;
  assign carry_flag      = s_q.carry;
  assign greater_flag    = s_q.gt;
  assign equal_flag      = s_q.eq;
  assign less_flag       = s_q.lt;

endmodule

// >>> testbench/cdalu_seq_model.sv
/*
  Sequencer model: Avalon-MM master of the datapath's register port.
  Assumes it shares clk with the design; the bench bounds every wait.
*/
`timescale 1ns/1ps
module cdalu_seq_model (
  input  wire logic        clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [9:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  int         slow  = 0;
  logic [3:0] lanes = 4'hF;
  initial begin
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    repeat (slow + 1) @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= lanes;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Released lines show a changed pattern, not the last value
    avs_address <= ~a;
    avs_writedata <= ~wd;
  endtask
endmodule

// >>> testbench/cdalu_top_checker.sv
/*
  Bus handshake and flag assertions for cdalu_top.
  Assumes only the top module's ports are visible; bound at the foot.
*/
`timescale 1ns/1ps
module cdalu_top_checker #(
  parameter int MEM_WORDS = 64
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        busy,
  input wire logic        carry_flag,
  input wire logic        greater_flag,
  input wire logic        equal_flag,
  input wire logic        less_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_exec_req;
    avs_write && avs_waitrequest && !busy && avs_address == 10'h010 &&
      avs_writedata[0] && avs_byteenable[0];
  endsequence
  // Longest counted op is 255 steps plus the execute step
  sequence s_run_done;
    busy ##[1:260] !busy;
  endsequence
  chk_exec_runs_done: assert property (s_exec_req |=> s_run_done)
    else $error("execute did not run and finish in time");
  chk_wait_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered next cycle");
  chk_write_idle_ack: assert property (avs_write && avs_waitrequest && !busy |=> !avs_waitrequest)
    else $error("idle write not answered next cycle");
  chk_write_busy_held: assert property (avs_write && busy |=> avs_waitrequest)
    else $error("write answered while busy");
  chk_flag_one_hot: assert property (greater_flag || equal_flag || less_flag |->
    $onehot({greater_flag, equal_flag, less_flag}))
    else $error("more than one compare flag on");
  chk_flags_idle_hold: assert property (!busy |=>
    $stable({carry_flag, greater_flag, equal_flag, less_flag}))
    else $error("flags changed without execute");
  chk_reset_quiet_out: assert property ($fell(rst) |-> !busy && avs_waitrequest)
    else $error("outputs not quiet after reset");
endmodule

bind cdalu_top cdalu_top_checker #(.MEM_WORDS(MEM_WORDS)) u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy),
  .carry_flag(carry_flag), .greater_flag(greater_flag), .equal_flag(equal_flag),
  .less_flag(less_flag)
);

// >>> testbench/tb_controller_data_conversion_alu.sv
/*
  Self-checking bench: random and corner operations through the register port.
  Assumes the sequencer model drives the bus and the checker is bound.
*/
`timescale 1ns/1ps
module tb_controller_data_conversion_alu;
  import cdalu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rq, wr, wt, busy, cf, gf, ef, lf;
  logic [9:0] ad;
  logic [31:0] wd, rdat, res, st, rd, s1, s2, d;
  logic [3:0] be;
  logic [32:0] e;
  logic [1:0] sz;
  logic dr, en, pc;
  int n_fail = 0, total_checks = 0, cyc = 0, w, t;
  cdalu_op_t op;
  localparam logic [6:0] SEVEN_TAB [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
    7'h7D, 7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  cdalu_top #(.MEM_WORDS(64)) dut (.clk(clk), .rst(rst), .avs_address(ad), .avs_read(rq),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .busy(busy), .carry_flag(cf), .greater_flag(gf),
    .equal_flag(ef), .less_flag(lf));
  cdalu_seq_model seq (.clk(clk), .avs_waitrequest(wt), .avs_readdata(rdat),
    .avs_address(ad), .avs_read(rq), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [31:0] msk(input logic [1:0] z, input logic [31:0] v);
    return z == 2'h0 ? {24'h0, v[7:0]} : z == 2'h1 ? {16'h0, v[15:0]} : v;
  endfunction
  function automatic logic [31:0] bcd2bin(input logic [31:0] v);
    logic [31:0] r = 32'h0;
    for (int k = 7; k >= 0; k--) r = r * 10 + v[4*k +: 4];
    return r;
  endfunction
  function automatic logic [31:0] bin2bcd(input logic [31:0] v);
    logic [31:0] r = 32'h0;
    for (int k = 0; k < 8; k++) begin
      r[4*k +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction
  function automatic logic [32:0] exp_op(input cdalu_op_t o, input logic [31:0] a, b, dd,
                                         input logic [1:0] z, input logic dir, ent, c);
    logic [31:0] x, y;
    logic [3:0] p = 4'h0;
    int n = z == 2'h0 ? 8 : z == 2'h1 ? 16 : 32;
    x = msk(z, a);
    y = msk(z, b);
    for (int k = 15; k >= 0; k--) if (a[k]) p = 4'(k);
    case (o)
      parity_make_odd:   return {c, 24'h0, ~^a[6:0], a[6:0]};
      parity_make_even:  return {c, 24'h0, ^a[6:0], a[6:0]};
      parity_check_odd:  return {~^x, 32'h0};
      parity_check_even: return {^x, 32'h0};
      decimal_to_binary: return {c, msk(z, bcd2bin(x))};
      binary_to_decimal: return {c, msk(z, bin2bcd(x))};
      one_hot_decode:    return {c, 32'h1 << a[3:0]};
      priority_encode:   return {c, dd[31:4], p};
      bit_set_op:        return {c, dd | (32'h1 << a[4:0])};
      bit_clear_op:      return {c, dd & ~(32'h1 << a[4:0])};
      bit_extract_op:    return {y[a[4:0]], 32'h0};
      ones_count:        return {c, 32'($countones(x))};
      shift_right_one:   return {x[0], (x >> 1) | (32'(ent) << (n - 1))};
      shift_left_one:    return {x[n-1], msk(z, (x << 1) | 32'(ent))};
      shift_right_count: return {c, x >> b[5:0]};
      shift_left_count:  return {c, msk(z, x << b[5:0])};
      shift_dir_one:     return {c, dir ? msk(z, x << 1) : x >> 1};
      default:           return {c, dir ? msk(z, x << b[5:0]) : x >> b[5:0]};
    endcase
  endfunction
  task automatic run_op(input cdalu_op_t o, input logic [31:0] a, b, dd, ctl);
    seq.xfer(1'b1, 10'h000, {27'h0, o}, rd);
    seq.xfer(1'b1, 10'h004, a, rd);
    seq.xfer(1'b1, 10'h008, b, rd);
    seq.xfer(1'b1, 10'h00C, dd, rd);
    seq.xfer(1'b1, 10'h010, ctl | 32'h1, rd);
    // Ignored write; a counted run holds it off until idle
    seq.xfer(1'b1, 10'h01C, 32'h0, rd);
    do seq.xfer(1'b0, 10'h014, 32'h0, st); while (st[4] !== 1'b0);
    seq.xfer(1'b0, 10'h018, 32'h0, res);
    check({31'h0, busy}, 32'h0);
  endtask
  initial begin
    t = $urandom(39);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    seq.xfer(1'b0, 10'h014, 32'h0, rd);
    check(rd, 32'h0);
    seq.xfer(1'b0, 10'h100, 32'h0, rd);
    check(rd, 32'h0);
    // Execute bit in lane 0 only: other lanes must not start anything
    seq.xfer(1'b1, 10'h000, {27'h0, one_hot_decode}, rd);
    seq.lanes = 4'hE;
    seq.xfer(1'b1, 10'h010, 32'h1, rd);
    seq.lanes = 4'hF;
    seq.xfer(1'b0, 10'h018, 32'h0, rd);
    check(rd, 32'h0);
    $display("test reset and refusals done");
    pc = 1'b0;
    for (int i = 0; i < 150; i++) begin
      do op = cdalu_op_t'(5'($urandom_range(0, 26)));
      while (op inside {[char_to_binary:binary_to_char],
                        [segment_encode:code_table_out_converted]});
      sz = 2'($urandom_range(0, 2));
      w = sz == 2'h0 ? 8 : sz == 2'h1 ? 16 : 32;
      {s1, s2, d, dr, en} = {$urandom, $urandom, msk(sz, $urandom), 2'($urandom)};
      seq.slow = $urandom_range(0, 2);
      if (op == decimal_to_binary) s1 = s1 & 32'h7777_7777;
      if (op == binary_to_decimal) s1 = s1 % (sz == 2'h0 ? 100 : sz == 2'h1 ? 10000 : 100000000);
      if (op inside {bit_set_op, bit_clear_op, bit_extract_op}) s1 = $urandom_range(0, w - 1);
      if (op >= shift_right_count) s2 = $urandom_range(0, w - 1);
      if (op == compare_op && i % 3 == 0) s2 = s1;
      if (op == priority_encode && i % 2 == 0) s1 = i % 4 ? 32'h0 : 32'h8000;
      e = exp_op(op, s1, s2, d, sz, dr, en, pc);
      run_op(op, s1, s2, d, {26'h0, sz, 1'b0, en, dr, 1'b0});
      if (!(op inside {parity_check_odd, parity_check_even, compare_op, bit_extract_op}))
        check(res, e[31:0]);
      if (op inside {parity_check_odd, parity_check_even, bit_extract_op} || op >= shift_right_one)
        check({31'h0, st[0]}, {31'h0, e[32]});
      if (op == compare_op) begin
        s1 = msk(sz, s1);
        s2 = msk(sz, s2);
        check({28'h0, st[3:1]}, {28'h0, s1 < s2, s1 == s2, s1 > s2});
        check({29'h0, lf, ef, gf}, {29'h0, s1 < s2, s1 == s2, s1 > s2});
      end
      check({31'h0, cf}, {31'h0, e[32]});
      pc = st[0];
    end
    $display("test random operations done");
    seq.slow = 0;
    t = $urandom_range(0, 863999);
    run_op(ticks_to_time, t, 32'h0, 32'hA, 32'h20);
    seq.xfer(1'b0, 10'h228, 32'h0, rd);
    check(rd, {16'h0, 8'(bin2bcd((t / 600) % 60)), 8'(bin2bcd((t / 10) % 60))});
    seq.xfer(1'b0, 10'h22C, 32'h0, rd);
    check(rd, {24'h0, 8'(bin2bcd(t / 36000))});
    run_op(time_to_ticks, 32'hA, 32'h0, 32'hC, 32'h20);
    check(res, t - t % 10);
    $display("test time of day done");
    run_op(code_table_set, 32'h1234, 32'h3, 32'h14, 32'h20);
    run_op(code_table_out_converted, 32'h3, 32'h14, 32'h28, 32'h20);
    check(res, 32'h4D2);
    seq.xfer(1'b0, 10'h2A4, 32'h0, rd);
    check(rd, 32'h1234);
    run_op(code_table_out_raw, 32'h3, 32'h14, 32'h2A, 32'h20);
    check(res, 32'h1234);
    $display("test code table done");
    // Value split over two words, spelt out as eight hex characters, read back
    s1 = $urandom;
    seq.xfer(1'b1, 10'h200, {16'h0, s1[15:0]}, rd);
    seq.xfer(1'b1, 10'h204, {16'h0, s1[31:16]}, rd);
    run_op(binary_to_char, 32'h0, 32'h8, 32'h2, 32'h20);
    for (int i = 0; i < 8; i++) begin
      seq.xfer(1'b0, 10'h208 + 10'(4 * i), 32'h0, rd);
      w = s1[4*(7-i) +: 4];
      check(rd, w < 10 ? 32'h30 + w : 32'h37 + w);
    end
    run_op(char_to_binary, 32'h2, 32'h8, 32'h10, 32'h20);
    check(res, s1);
    $display("test character codes done");
    for (int i = 0; i < 16; i++) seq.xfer(1'b1, 10'h2C0 + 10'(4 * i), 32'(i), rd);
    run_op(segment_encode, 32'h30, 32'h10, 32'h20, 32'h20);
    for (int i = 0; i < 16; i++) begin
      seq.xfer(1'b0, 10'h280 + 10'(4 * i), 32'h0, rd);
      check(rd, {25'h0, SEVEN_TAB[i]});
    end
    $display("test segment encode done");
    complete_run();
  end
endmodule
